// [bench/tb_top.sv]
// self-checking bench: apb register traffic and serial frames both ways
// assumes: design, checker and remote model compiled before this file
`timescale 1ns/1ps
`default_nettype none
`include "uirc_defs.vh"
module tb_top;
   logic        sys_clk_in  = 1'h0;
   logic        srst_in     = 1'h1;
   logic        psel_in     = 1'h0;
   logic        penable_in  = 1'h0;
   logic        pwrite_in   = 1'h0;
   logic [11:0] paddr_in    = 12'h000;
   logic [31:0] pwdata_in   = 32'h0000_0000;
   logic [31:0] prdata_out;
   logic        pready_out, pslverr_out, err_s, rx_line, tx_pin, tx_oe_n, tx_ev, rx_ev;
   logic        sys_idle_r  = 1'h0;
   int          tx_evs      = 0;
   int          rx_evs      = 0;
   int          bad_count   = 0;
   int          checks_done = 0;
   int          cycles      = 0;
   // released tx pin floats to its pull-up level
   wire         tx_line     = tx_oe_n ? 1'h1 : tx_pin;
   uirc_top dut_u (
      .sys_clk_in(sys_clk_in), .srst_in(srst_in), .psel_in(psel_in), .penable_in(penable_in),
      .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .pstrb_in(4'hF),
      .pready_out(pready_out), .prdata_out(prdata_out), .pslverr_out(pslverr_out),
      .sys_idle_in(sys_idle_r), .sys_sleep_in(1'h0), .serial_in_pin_in(rx_line),
      .clear_to_send_pin_n_in(1'h0), .serial_out_pin_out(tx_pin), .serial_out_oe_n_out(tx_oe_n),
      .request_to_send_pin_n_out(), .request_to_send_oe_n_out(), .baud_clock_out_pin_out(),
      .baud_clock_oe_n_out(), .tx_event_out(tx_ev), .rx_event_out(rx_ev), .wake_event_out());
   uirc_remote #(.BIT_CLKS(16)) remote_u (.clk_in(sys_clk_in), .line_in(tx_line), .line_out(rx_line));
   always #5 sys_clk_in = ~sys_clk_in;
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // the run needs about 2400 cycles, so this only trips on a hang
   always @(posedge sys_clk_in) begin
      cycles <= cycles + 1;
      // event pulses are counted so scenarios can judge them by difference
      if (tx_ev === 1'h1)
         tx_evs <= tx_evs + 1;
      if (rx_ev === 1'h1)
         rx_evs <= rx_evs + 1;
      if (cycles == 10000) begin
         bad_count++;
         finish_test();
      end
   end
   task automatic check(input logic [31:0] got, input logic [31:0] want);
      checks_done++;
      if (got !== want) begin
         bad_count++;
         $display("BAD %0t got %h want %h", $time, got, want);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d, output logic [31:0] r);
      psel_in    <= 1'h1;
      pwrite_in  <= w;
      paddr_in   <= a;
      pwdata_in  <= {16'h0000, d};
      @(posedge sys_clk_in);
      penable_in <= 1'h1;
      @(posedge sys_clk_in);
      while (pready_out !== 1'h1) @(posedge sys_clk_in);
      r = prdata_out;
      err_s = pslverr_out;
      psel_in    <= 1'h0;
      penable_in <= 1'h0;
      @(posedge sys_clk_in);
   endtask
   task automatic wr(input logic [11:0] a, input logic [15:0] d);
      logic [31:0] r;
      apb(1'h1, a, d, r);
   endtask
   task automatic rd_chk(input logic [11:0] a, input logic [31:0] want);
      logic [31:0] r;
      apb(1'h0, a, 16'h0000, r);
      check(r, want);
   endtask
   task automatic test_reset();
      rd_chk(`UIRC_A_MODE, 32'h0000_0000);
      rd_chk(`UIRC_A_STA, 32'h0000_0110);
      rd_chk(12'h020, 32'h0000_0000);
      check({31'h0, err_s}, 32'h0000_0001);
      $display("test_reset done");
   endtask
   task automatic test_tx();
      wr(`UIRC_A_MODE, 16'h8300);
      wr(`UIRC_A_STA, 16'h0400);
      for (int i = 0; i < 5; i++)
         wr(`UIRC_A_TXD, 16'h00A0 + 16'(i));
      rd_chk(`UIRC_A_STA, 32'h0000_0610);
      while (remote_u.got_q.size() < 5) @(posedge sys_clk_in);
      for (int i = 0; i < 5; i++)
         check({24'h0, remote_u.got_q[i]}, 32'h0000_00A0 + i);
      // the fifth frame still owes its stop bit
      repeat (16) @(posedge sys_clk_in);
      rd_chk(`UIRC_A_STA, 32'h0000_0510);
      wr(`UIRC_A_TXD, 16'h00C3);
      wr(`UIRC_A_TXD, 16'h00C4);
      wr(`UIRC_A_STA, 16'h0000);
      rd_chk(`UIRC_A_STA, 32'h0000_0110);
      $display("test_tx done");
   endtask
   task automatic test_rx();
      logic [7:0] d;
      wr(`UIRC_A_MODE, 16'h8002);
      for (int i = 0; i < 5; i++) begin
         d = 8'h30 + 8'(i);
         // the second character carries a wrong parity bit
         remote_u.send({^d ^ (i == 1), d}, 9);
      end
      rd_chk(`UIRC_A_STA, 32'h0000_0113);
      rd_chk(`UIRC_A_RXD, 32'h0000_0030);
      rd_chk(`UIRC_A_STA, 32'h0000_011B);
      rd_chk(`UIRC_A_RXD, 32'h0000_0031);
      rd_chk(`UIRC_A_STA, 32'h0000_0113);
      wr(`UIRC_A_STA, 16'h0000);
      rd_chk(`UIRC_A_STA, 32'h0000_0110);
      rd_chk(`UIRC_A_RXD, 32'h0000_0000);
      $display("test_rx done");
   endtask
   task automatic test_loop();
      logic [31:0] r;
      int          t0;
      int          r0;
      t0 = tx_evs;
      r0 = rx_evs;
      // nine-bit frames, two stops, address detect, looped back internally
      wr(`UIRC_A_MODE, 16'h8047);
      wr(`UIRC_A_STA, 16'h2420);
      wr(`UIRC_A_TXD, 16'h0155);
      wr(`UIRC_A_TXD, 16'h00AA);
      do
         apb(1'h0, `UIRC_A_STA, 16'h0000, r);
      while (r[8] !== 1'h1);
      check(r, 32'h0000_2531);
      rd_chk(`UIRC_A_RXD, 32'h0000_0155);
      rd_chk(`UIRC_A_STA, 32'h0000_2530);
      check(tx_evs - t0, 1);
      check(rx_evs - r0, 1);
      $display("test_loop done");
   endtask
   task automatic test_idle();
      logic [31:0] r;
      wr(`UIRC_A_MODE, 16'hA000);
      wr(`UIRC_A_STA, 16'h0400);
      sys_idle_r <= 1'h1;
      wr(`UIRC_A_TXD, 16'h0055);
      repeat (40) @(posedge sys_clk_in);
      rd_chk(`UIRC_A_STA, 32'h0000_0410);
      sys_idle_r <= 1'h0;
      do
         apb(1'h0, `UIRC_A_STA, 16'h0000, r);
      while (r[8] !== 1'h1);
      check(r, 32'h0000_0510);
      check({24'h0, remote_u.got_q[remote_u.got_q.size() - 1]}, 32'h0000_0055);
      $display("test_idle done");
   endtask
   initial begin
      repeat (8) @(posedge sys_clk_in);
      srst_in <= 1'h0;
      @(posedge sys_clk_in);
      test_reset();
      test_tx();
      test_rx();
      test_loop();
      test_idle();
      finish_test();
   end
endmodule // tb_top
`default_nettype wire

// [bench/uirc_properties.sv]
// checker for the serial transceiver's bus and pin-release ports
// assumes: bound to uirc_top, writes always carry full byte strobes
`timescale 1ns/1ps
`default_nettype none
module uirc_props (
   input wire logic        sys_clk_in,
   input wire logic        srst_in,
   input wire logic        psel_in,
   input wire logic        penable_in,
   input wire logic        pwrite_in,
   input wire logic [11:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   input wire logic        pready_out,
   input wire logic [31:0] prdata_out,
   input wire logic        pslverr_out,
   input wire logic        serial_out_oe_n_out,
   input wire logic        request_to_send_oe_n_out,
   input wire logic        baud_clock_oe_n_out
);
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (srst_in);
   logic [15:0] mode_r;
   logic        txen_r;
   wire         wr_w = psel_in && penable_in && pready_out && pwrite_in;
   // shadow of written values; only plain r/w bits are checked, so hardware self-clears cannot skew it
   always @(posedge sys_clk_in) begin
      if (srst_in) begin
         mode_r <= 16'h0000;
         txen_r <= 1'h0;
      end else if (wr_w && paddr_in == 12'h000) begin
         mode_r <= pwdata_in[15:0];
      end else if (wr_w && paddr_in == 12'h004) begin
         txen_r <= pwdata_in[10];
      end
   end
   sequence setup_s;
      psel_in && !penable_in;
   endsequence
   sequence off_s;
      !mode_r[15] ##1 !mode_r[15];
   endsequence
   chk_wait_state:
      assert property (setup_s ##1 (psel_in && penable_in) |-> !pready_out ##1 pready_out) else $error("no wait state");
   chk_ready_pulse:
      assert property (pready_out |=> !pready_out) else $error("pready too long");
   chk_rdata_upper:
      assert property (pready_out |-> prdata_out[31:16] == 16'h0000) else $error("upper read half set");
   chk_slverr_map:
      assert property (pready_out |-> pslverr_out == (paddr_in > 12'h010)) else $error("slave error mismatch");
   chk_pins_released:
      assert property (off_s |-> serial_out_oe_n_out && request_to_send_oe_n_out && baud_clock_oe_n_out)
         else $error("pins driven while disabled");
   chk_tx_released:
      assert property (!txen_r ##1 !txen_r |-> serial_out_oe_n_out) else $error("tx pin driven while off");
   chk_field_off:
      assert property ((mode_r[9:8] == 2'h0) [*2] |-> request_to_send_oe_n_out && baud_clock_oe_n_out)
         else $error("rts pin driven in field 00");
   chk_bclk_on:
      assert property ((mode_r[15] && mode_r[9:8] == 2'h3) [*2] |-> !baud_clock_oe_n_out)
         else $error("baud clock pin not driven");
endmodule // uirc_props
bind uirc_top uirc_props chk_u (
   .sys_clk_in(sys_clk_in), .srst_in(srst_in), .psel_in(psel_in), .penable_in(penable_in),
   .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .pready_out(pready_out),
   .prdata_out(prdata_out), .pslverr_out(pslverr_out), .serial_out_oe_n_out(serial_out_oe_n_out),
   .request_to_send_oe_n_out(request_to_send_oe_n_out), .baud_clock_oe_n_out(baud_clock_oe_n_out));
`default_nettype wire

// [bench/uirc_remote.sv]
// remote serial transceiver facing the block's pins
// assumes: line idles high, lsb first, one bit lasts BIT_CLKS clocks
`timescale 1ns/1ps
`default_nettype none
module uirc_remote #(
   parameter int BIT_CLKS = 16
) (
   input  wire logic clk_in,
   input  wire logic line_in,
   output var  logic line_out
);
   logic [7:0] got_q[$];
   initial line_out = 1'h1;
   // start bit, nbits lsb first, one stop bit
   task automatic send(input logic [8:0] d, input int nbits);
      line_out <= 1'h0;
      repeat (BIT_CLKS) @(posedge clk_in);
      for (int i = 0; i < nbits; i++) begin
         line_out <= d[i];
         repeat (BIT_CLKS) @(posedge clk_in);
      end
      line_out <= 1'h1;
      repeat (BIT_CLKS) @(posedge clk_in);
   endtask
   // 8 data bits sampled mid-bit; anything after them is ignored
   initial begin
      logic [7:0] b;
      forever begin
         @(negedge line_in);
         repeat (BIT_CLKS * 3 / 2) @(posedge clk_in);
         for (int i = 0; i < 8; i++) begin
            b[i] = line_in;
            repeat (BIT_CLKS) @(posedge clk_in);
         end
         got_q.push_back(b);
      end
   end
endmodule // uirc_remote
`default_nettype wire

// [design/uirc_top.v]
// uirc_top.v: apb serial transceiver with infrared codec, 4-deep queues
// assumes: apb master on sys_clk_in, pins from outside, idle/sleep from same clock
`timescale 1ns/1ps
`default_nettype none
`include "uirc_defs.vh"
module uirc_top (
   // clock and reset
   input  wire        sys_clk_in,
   input  wire        srst_in,
   // apb slave
   input  wire        psel_in,
   input  wire        penable_in,
   input  wire        pwrite_in,
   input  wire [11:0] paddr_in,
   input  wire [31:0] pwdata_in,
   input  wire [3:0]  pstrb_in,
   output reg         pready_out,
   output reg  [31:0] prdata_out,
   output reg         pslverr_out,
   // system power state
   input  wire        sys_idle_in,
   input  wire        sys_sleep_in,
   // serial pins
   input  wire        serial_in_pin_in,
   input  wire        clear_to_send_pin_n_in,
   output reg         serial_out_pin_out,
   output reg         serial_out_oe_n_out,
   output reg         request_to_send_pin_n_out,
   output reg         request_to_send_oe_n_out,
   output reg         baud_clock_out_pin_out,
   output reg         baud_clock_oe_n_out,
   // events
   output reg         tx_event_out,
   output reg         rx_event_out,
   output reg         wake_event_out
);
   localparam TS_IDLE = 2'b01;
   localparam TS_RUN  = 2'b10;
   localparam RS_IDLE = 2'b01;
   localparam RS_RUN  = 2'b10;

   reg  [15:0] mode_r, ctl_r, brg_r, bcnt_r;
   reg         overrun_flag_r, wseen_r, rxp_r;
   reg  [1:0]  rx_s_r, cts_s_r;
   reg  [8:0]  txf [0:3];
   reg  [10:0] rxf [0:3];
   reg  [1:0]  twp_r, trp_r, rwp_r, rrp_r;
   reg  [2:0]  tcnt_r, rcnt_r, abe_r;
   reg  [1:0]  tst_r, rst_r;
   reg  [15:0] tsr_r;
   reg  [3:0]  tbits_r, rbits_r;
   reg  [4:0]  tsub_r, rsub_r, irh_r;
   reg         tbrk_r;
   reg  [11:0] rsr_r;
   reg  [23:0] abc_r;
   reg  [15:0] rdat;

   // bus decode; a transfer completes on the edge where pready_out is high
   wire acc      = psel_in & penable_in & pready_out;
   wire wr       = acc & pwrite_in;
   wire rd       = acc & ~pwrite_in;
   wire [15:0] bm = {{8{pstrb_in[1]}}, {8{pstrb_in[0]}}};
   wire h_mode   = (paddr_in == `UIRC_A_MODE);
   wire h_sta    = (paddr_in == `UIRC_A_STA);
   wire h_txd    = (paddr_in == `UIRC_A_TXD);
   wire h_rxd    = (paddr_in == `UIRC_A_RXD);
   wire h_brg    = (paddr_in == `UIRC_A_BRG);
   wire mapped   = h_mode | h_sta | h_txd | h_rxd | h_brg;

   // configuration
   wire en       = mode_r[`UIRC_M_EN];
   wire run      = en & ~(mode_r[`UIRC_M_SIDL] & sys_idle_in);
   wire high_speed_rate     = mode_r[`UIRC_M_HIGH_SPEED_RATE];
   wire irda     = mode_r[`UIRC_M_INFRARED_ENABLE] & ~high_speed_rate;
   wire [1:0] pen   = mode_r[`UIRC_M_PEN];
   wire [1:0] pdsel = mode_r[`UIRC_M_PDSEL];
   wire nine     = (pdsel == 2'b11);
   wire par_en   = (pdsel == 2'b01) | (pdsel == 2'b10);
   wire xbit     = nine | par_en;
   wire [4:0] osr = high_speed_rate ? `UIRC_OSR_HI : `UIRC_OSR_STD;
   wire txen     = ctl_r[`UIRC_S_TXEN];
   wire [1:0] txis = {ctl_r[`UIRC_S_TXIS1], ctl_r[`UIRC_S_TXIS0]};
   wire [1:0] rxis = ctl_r[`UIRC_S_RXIS];

   // baud tick: one per oversample clock
   wire tick     = run & (bcnt_r == brg_r);

   // transmit queue status
   wire tx_full  = (tcnt_r == `UIRC_DEPTH);
   wire tx_all_empty     = tst_r[0] & (tcnt_r == 3'd0);
   wire cts_ok   = (pen != 2'b10) | ~cts_s_r[1];
   wire tx_push  = wr & h_txd & pstrb_in[0] & en & ~tx_full;
   wire tx_pop   = tst_r[0] & txen & tick & cts_ok & (tcnt_r != 3'd0);
   wire tx_end   = tst_r[1] & tick & (tsub_r == osr - 5'd1) & (tbits_r == 4'd1);
   // clearing transmit enable aborts the frame and drops the queue
   wire tx_kill  = ~en | (wr & h_sta & bm[`UIRC_S_TXEN] & ~pwdata_in[`UIRC_S_TXEN] & txen);
   wire [8:0] thd = txf[trp_r];
   wire tpar     = (^thd[7:0]) ^ pdsel[1];
   wire tnine    = nine ? thd[8] : (par_en ? tpar : 1'b1);
   wire [3:0] tnb = 4'd10 + {3'b000, xbit} + {3'b000, mode_r[`UIRC_M_STOP_BIT_SELECT]};
   wire txbit    = tst_r[1] ? tsr_r[0] : 1'b1;
   // infrared: a zero bit becomes a short pulse at the start of the bit
   wire enc      = irda ? (tst_r[1] & ~txbit & (tsub_r < `UIRC_IR_PULSE)) : txbit;

   // receive path
   wire rx_raw   = mode_r[`UIRC_M_LPBK] ? serial_out_pin_out : rx_s_r[1];
   wire pol      = rx_raw ^ mode_r[`UIRC_M_RECEIVE_POLARITY];
   wire rxd      = irda ? (pol & (irh_r == 5'd0)) : pol;
   wire auto_rate_measure    = mode_r[`UIRC_M_AUTO_RATE_MEASURE];
   wire fall     = rxp_r & ~rxd;
   wire rise     = ~rxp_r & rxd;
   wire [3:0] rnb = 4'd10 + {3'b000, xbit};
   wire rsamp    = rst_r[1] & tick & (rsub_r == (osr >> 1));
   wire rlast    = rsamp & (rbits_r == rnb - 4'd1);
   wire [11:0] rfr = rsr_r | ({11'h000, rxd} << rbits_r);
   wire rd8      = nine & rfr[9];
   wire rperr    = par_en & ((^rfr[8:1]) ^ rfr[9] ^ pdsel[1]);
   wire rferr    = ~(xbit ? rfr[10] : rfr[9]);
   wire raccept  = ~(ctl_r[`UIRC_S_ADDRESS_DETECT_ENABLE] & nine & ~rd8);
   wire rx_done  = rlast & raccept;
   wire rx_full  = (rcnt_r == `UIRC_DEPTH);
   wire rx_push  = rx_done & ~rx_full;
   wire rx_ovf   = rx_done & rx_full;
   wire rx_pop   = rd & h_rxd & (rcnt_r != 3'd0);
   wire overrun_flag_clr = wr & h_sta & bm[`UIRC_S_OVERRUN_FLAG] & ~pwdata_in[`UIRC_S_OVERRUN_FLAG] & overrun_flag_r;
   wire rx_kill  = ~en | overrun_flag_clr;
   wire [10:0] rhd = (rcnt_r != 3'd0) ? rxf[rrp_r] : 11'h000;
   wire [2:0] rnew = rcnt_r + 3'd1;
   wire ab_done  = auto_rate_measure & run & fall & (abe_r == `UIRC_AB_EDGES - 3'd1);
   wire [23:0] abq = high_speed_rate ? (abc_r >> `UIRC_AB_SH_HI) : (abc_r >> `UIRC_AB_SH_STD);

   // pin synchronisers
   always @(posedge sys_clk_in) begin
      if (srst_in) begin
         rx_s_r  <= 2'b11;
         cts_s_r <= 2'b11;
      end else begin
         rx_s_r  <= {rx_s_r[0], serial_in_pin_in};
         cts_s_r <= {cts_s_r[0], clear_to_send_pin_n_in};
      end
   end

   // registers and apb answer; one wait state per transfer
   always @(posedge sys_clk_in) begin
      if (srst_in) begin
         mode_r      <= `UIRC_MODE_RST;
         ctl_r       <= `UIRC_CTL_RST;
         brg_r       <= `UIRC_BRG_RST;
         overrun_flag_r      <= 1'b0;
         wseen_r     <= 1'b0;
         pready_out  <= 1'b0;
         prdata_out  <= 32'h00000000;
         pslverr_out <= 1'b0;
         wake_event_out <= 1'b0;
      end else begin
         pready_out  <= psel_in & penable_in & ~pready_out;
         prdata_out  <= {16'h0000, rdat};
         pslverr_out <= psel_in & penable_in & ~pready_out & ~mapped;
         wake_event_out <= 1'b0;
         // hardware clears come first so a same-cycle software write wins
         if (ab_done)
            mode_r[`UIRC_M_AUTO_RATE_MEASURE] <= 1'b0;
         if (ab_done)
            brg_r <= abq[15:0] - 16'h0001;
         if (mode_r[`UIRC_M_WAKE] & en) begin
            if (fall & ~wseen_r) begin
               wake_event_out <= 1'b1;
               wseen_r        <= 1'b1;
            end else if (rise & wseen_r) begin
               mode_r[`UIRC_M_WAKE] <= 1'b0;
               wseen_r              <= 1'b0;
            end
         end else begin
            wseen_r <= 1'b0;
         end
         if (tx_end & tbrk_r)
            ctl_r[`UIRC_S_BRK] <= 1'b0;
         if (wr & h_mode)
            mode_r <= (mode_r & ~bm) | (pwdata_in[15:0] & bm & `UIRC_M_WMASK);
         if (wr & h_sta)
            ctl_r <= (ctl_r & ~bm) | (pwdata_in[15:0] & bm & `UIRC_S_WMASK);
         if (wr & h_brg)
            brg_r <= (brg_r & ~bm) | (pwdata_in[15:0] & bm);
         // overrun: a set in the same cycle as the clear wins
         if (rx_ovf)
            overrun_flag_r <= 1'b1;
         else if (overrun_flag_clr | ~en)
            overrun_flag_r <= 1'b0;
      end
   end

   always @* begin
      rdat = 16'h0000;
      case (1'b1)
         h_mode:  rdat = mode_r;
         h_sta:   rdat = ctl_r | {6'h00, tx_full, tx_all_empty, 3'h0, rst_r[0], rhd[9], rhd[10],
                                  overrun_flag_r, (rcnt_r != 3'd0)};
         h_rxd:   rdat = {7'h00, rhd[8:0]};
         h_brg:   rdat = brg_r;
         default: rdat = 16'h0000;
      endcase
   end

   // baud generator; a divisor write restarts it at once
   always @(posedge sys_clk_in) begin
      if (srst_in | ~en | (wr & h_brg))
         bcnt_r <= 16'h0000;
      else if (run)
         bcnt_r <= tick ? 16'h0000 : bcnt_r + 16'h0001;
   end

   // transmitter and its queue
   always @(posedge sys_clk_in) begin
      if (srst_in | tx_kill) begin
         tst_r   <= TS_IDLE;
         tsr_r   <= 16'hFFFF;
         tbits_r <= 4'd0;
         tsub_r  <= 5'd0;
         tbrk_r  <= 1'b0;
         twp_r   <= 2'd0;
         trp_r   <= 2'd0;
         tcnt_r  <= 3'd0;
         tx_event_out <= 1'b0;
      end else begin
         tx_event_out <= 1'b0;
         if (tx_push) begin
            txf[twp_r] <= pwdata_in[8:0];
            twp_r      <= twp_r + 2'd1;
         end
         tcnt_r <= tcnt_r + {2'b00, tx_push} - {2'b00, tx_pop};
         case (tst_r)
            TS_IDLE: begin
               if (tx_pop) begin
                  trp_r  <= trp_r + 2'd1;
                  tsub_r <= 5'd0;
                  tst_r  <= TS_RUN;
                  if (ctl_r[`UIRC_S_BRK]) begin
                     // the queued character is a dummy and is not sent
                     tsr_r   <= 16'hE000;
                     tbits_r <= `UIRC_BRK_FRAME;
                     tbrk_r  <= 1'b1;
                  end else begin
                     tsr_r   <= {6'h3F, tnine, thd[7:0], 1'b0};
                     tbits_r <= tnb;
                     tbrk_r  <= 1'b0;
                  end
                  if ((txis == 2'b00) | ((txis == 2'b10) & (tcnt_r == 3'd1)))
                     tx_event_out <= 1'b1;
               end
            end
            TS_RUN: begin
               if (tick) begin
                  if (tsub_r == osr - 5'd1) begin
                     tsub_r  <= 5'd0;
                     tsr_r   <= {1'b1, tsr_r[15:1]};
                     tbits_r <= tbits_r - 4'd1;
                     if (tbits_r == 4'd1) begin
                        tst_r  <= TS_IDLE;
                        tbrk_r <= 1'b0;
                        if ((txis == 2'b01) & (tcnt_r == 3'd0) & ~tx_push)
                           tx_event_out <= 1'b1;
                     end
                  end else begin
                     tsub_r <= tsub_r + 5'd1;
                  end
               end
            end
            default: tst_r <= TS_IDLE;
         endcase
      end
   end

   // receiver, infrared pulse stretcher and auto-baud measurement
   always @(posedge sys_clk_in) begin
      if (srst_in | rx_kill) begin
         rst_r   <= RS_IDLE;
         rsr_r   <= 12'h000;
         rbits_r <= 4'd0;
         rsub_r  <= 5'd0;
         rwp_r   <= 2'd0;
         rrp_r   <= 2'd0;
         rcnt_r  <= 3'd0;
         irh_r   <= 5'd0;
         rxp_r   <= 1'b1;
         abe_r   <= 3'd0;
         abc_r   <= 24'h000000;
         rx_event_out <= 1'b0;
      end else begin
         rx_event_out <= 1'b0;
         rxp_r <= rxd;
         // a pulse holds the decoded line low for one bit time
         if (~pol)
            irh_r <= `UIRC_IR_HOLD;
         else if (tick & (irh_r != 5'd0))
            irh_r <= irh_r - 5'd1;
         if (rx_pop)
            rrp_r <= rrp_r + 2'd1;
         if (rx_push) begin
            rxf[rwp_r] <= {rferr, rperr, rd8, rfr[8:1]};
            rwp_r      <= rwp_r + 2'd1;
            if (~rxis[1] | ((rxis == 2'b10) & (rnew == 3'd3)) | ((rxis == 2'b11) & (rnew == 3'd4)))
               rx_event_out <= 1'b1;
         end
         rcnt_r <= rcnt_r + {2'b00, rx_push} - {2'b00, rx_pop};
         // auto-baud: five falling edges of 0x55 span eight bit times
         if (~auto_rate_measure | ~run) begin
            abe_r <= 3'd0;
            abc_r <= 24'h000000;
         end else begin
            if (abe_r != 3'd0)
               abc_r <= abc_r + 24'h000001;
            if (fall)
               abe_r <= ab_done ? 3'd0 : abe_r + 3'd1;
         end
         case (rst_r)
            RS_IDLE: begin
               // the sync character is measured, not received
               if (tick & ~rxd & ~auto_rate_measure) begin
                  rst_r   <= RS_RUN;
                  rsub_r  <= 5'd0;
                  rbits_r <= 4'd0;
                  rsr_r   <= 12'h000;
               end
            end
            RS_RUN: begin
               if (tick)
                  rsub_r <= (rsub_r == osr - 5'd1) ? 5'd0 : rsub_r + 5'd1;
               if (rsamp) begin
                  rsr_r   <= rfr;
                  rbits_r <= rbits_r + 4'd1;
                  if (rlast | ((rbits_r == 4'd0) & rxd))
                     rst_r <= RS_IDLE;
               end
            end
            default: rst_r <= RS_IDLE;
         endcase
      end
   end

   // pin drivers; all pins go to port control while the module is off
   always @(posedge sys_clk_in) begin
      if (srst_in) begin
         serial_out_pin_out        <= 1'b1;
         serial_out_oe_n_out       <= 1'b1;
         request_to_send_pin_n_out <= 1'b1;
         request_to_send_oe_n_out  <= 1'b1;
         baud_clock_out_pin_out    <= 1'b0;
         baud_clock_oe_n_out       <= 1'b1;
      end else begin
         serial_out_pin_out        <= enc ^ ctl_r[`UIRC_S_TXINV];
         serial_out_oe_n_out       <= ~(en & txen);
         // simplex: asserted while sending; flow control: asserted while room
         request_to_send_pin_n_out <= mode_r[`UIRC_M_RTS_PIN_MODE] ? tx_all_empty : rx_full;
         request_to_send_oe_n_out  <= ~(en & ((pen == 2'b01) | (pen == 2'b10)));
         baud_clock_out_pin_out    <= en & (bcnt_r <= (brg_r >> 1));
         baud_clock_oe_n_out       <= ~(en & (pen == 2'b11));
      end
   end
endmodule // uirc_top
`default_nettype wire

// [shared/uirc_defs.vh]
// uirc_defs.vh: register offsets, field positions, reset values and counts
// assumes: included by bare name from the serial transceiver design file
`ifndef UIRC_DEFS_VH
`define UIRC_DEFS_VH
// apb byte offsets
`define UIRC_A_MODE     12'h000
`define UIRC_A_STA      12'h004
`define UIRC_A_TXD      12'h008
`define UIRC_A_RXD      12'h00C
`define UIRC_A_BRG      12'h010
// serial_mode_control fields
`define UIRC_M_EN       15
`define UIRC_M_SIDL     13
`define UIRC_M_INFRARED_ENABLE     12
`define UIRC_M_RTS_PIN_MODE    11
`define UIRC_M_PEN      9:8
`define UIRC_M_WAKE     7
`define UIRC_M_LPBK     6
`define UIRC_M_AUTO_RATE_MEASURE    5
`define UIRC_M_RECEIVE_POLARITY    4
`define UIRC_M_HIGH_SPEED_RATE     3
`define UIRC_M_PDSEL    2:1
`define UIRC_M_STOP_BIT_SELECT    0
`define UIRC_M_WMASK    16'hBBFF
// serial_status_control fields
`define UIRC_S_TXIS1    15
`define UIRC_S_TXINV    14
`define UIRC_S_TXIS0    13
`define UIRC_S_BRK      11
`define UIRC_S_TXEN     10
`define UIRC_S_RXIS     7:6
`define UIRC_S_ADDRESS_DETECT_ENABLE    5
`define UIRC_S_OVERRUN_FLAG     1
`define UIRC_S_WMASK    16'hECE0
// reset values
`define UIRC_MODE_RST   16'h0000
`define UIRC_CTL_RST    16'h0000
`define UIRC_BRG_RST    16'h0000
// counts
`define UIRC_DEPTH      3'd4
`define UIRC_OSR_STD    5'd16
`define UIRC_OSR_HI     5'd4
`define UIRC_BRK_FRAME  4'd14
`define UIRC_IR_PULSE   5'd3
`define UIRC_IR_HOLD    5'd16
`define UIRC_AB_EDGES   3'd5
`define UIRC_AB_SH_STD  7
`define UIRC_AB_SH_HI   5
`endif
